// *** design/cfg_word_store.sv ***
// Write-only configuration register pair captured on the write strobe
`timescale 1ns/1ns
module cfg_word_store #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 10
) (
    // Write port
    input wire logic wr_n_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [DATA_W-1:0] cfg_word_in_i,
    // Stored words and write toggle
    output logic [DATA_W-1:0] structure_o,
    output logic [DATA_W-1:0] format_o,
    output logic wr_toggle_o
);
    // Strobe rising edge stores the word; toggle marks a control write
    // Coefficient addresses never match a control register here [RULE23]
    always_ff @(posedge wr_n_i or negedge arst_n_i) begin // [RULE12]
        if (!arst_n_i) begin
            structure_o <= fir_ctrl_pkg::CFG_RESET;
            format_o <= fir_ctrl_pkg::CFG_RESET;
            wr_toggle_o <= 1'b0;
        end else if (cfg_addr_i == fir_ctrl_pkg::ADDR_STRUCT) begin
            structure_o <= cfg_word_in_i; // [RULE9]
            wr_toggle_o <= ~wr_toggle_o; // [RULE11]
        end else if (cfg_addr_i == fir_ctrl_pkg::ADDR_FORMAT) begin
            format_o <= cfg_word_in_i; // [RULE9]
            wr_toggle_o <= ~wr_toggle_o;
        end
    end
endmodule

// *** design/fir_ctrl_top.sv ***
// Control pins, configuration decode and output enables of the dual FIR
`timescale 1ns/1ns
module fir_ctrl_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control pins
    input wire logic shift_hold_n_i,
    input wire logic forward_operand_sel_n_i,
    input wire logic reverse_operand_sel_n_i,
    input wire logic lifo_swap_n_i,
    input wire logic accumulate_gate_i,
    input wire logic [1:0] combiner_ctrl_i,
    // Output enables
    input wire logic low_bits_drive_n_i,
    input wire logic high_bits_drive_n_i,
    // Configuration port
    input wire logic wr_n_i,
    input wire logic [8:0] cfg_addr_i,
    input wire logic [9:0] cfg_word_in_i,
    // Sample ports and result from the datapath
    input wire logic [9:0] sample_port_a_i,
    input wire logic [9:0] sample_port_b_i,
    input wire logic [8:0] shared_b_upper_bits_i,
    input wire logic [27:0] filter_result_i,
    // Registered samples and operand gates
    output logic [9:0] sample_a_o,
    output logic [9:0] sample_b_o,
    output logic shift_en_o,
    output logic fwd_pass_o,
    output logic rev_pass_o,
    output logic subtract_o,
    output logic negate_a_o,
    output logic lifo_sel_o,
    output logic acc_feedback_en_o,
    output logic acc_load_o,
    output logic [1:0] combiner_o,
    output logic [3:0] decim_delay_m1_o,
    output logic [4:0] decim_factor_o,
    // Decoded configuration
    output logic dual_mode_o,
    output logic odd_sym_o,
    output logic even_taps_a_o,
    output logic even_taps_b_o,
    output logic b_from_own_port_o,
    output logic interleaved_o,
    output logic [3:0] signed_fmt_o,
    output logic reversal_en_o,
    output logic round_en_o,
    output logic [11:0] round_weight_o,
    output logic internal_reset_o,
    // Result pins
    output logic [8:0] result_low_bits_o,
    output logic result_low_bits_oe_n_o,
    output logic [18:0] result_high_bits_o,
    output logic result_high_bits_oe_n_o
);
    // ****************************************************************
    // Configuration capture
    // ****************************************************************
    logic [9:0] structure;
    logic [9:0] format;
    logic wr_toggle;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [2:0] rst_cnt;
    logic [9:0] cfg_s1;
    logic [9:0] fmt_s1;
    logic [9:0] cfg_q;
    logic [9:0] fmt_q;

    cfg_word_store #(
        .ADDR_W(fir_ctrl_pkg::ADDR_W),
        .DATA_W(fir_ctrl_pkg::DATA_W)
    ) u_store (
        .wr_n_i(wr_n_i),
        .arst_n_i(arst_n_i),
        .cfg_addr_i(cfg_addr_i),
        .cfg_word_in_i(cfg_word_in_i),
        .structure_o(structure),
        .format_o(format),
        .wr_toggle_o(wr_toggle)
    );

    // Write toggle crosses into clock domain
    always_ff @(posedge clk_i or negedge arst_n_i) begin // [RULE12]
        if (!arst_n_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= wr_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // Words are stable by the time the synced toggle arrives
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_s1 <= fir_ctrl_pkg::CFG_RESET;
            fmt_s1 <= fir_ctrl_pkg::CFG_RESET;
            cfg_q <= fir_ctrl_pkg::CFG_RESET;
            fmt_q <= fir_ctrl_pkg::CFG_RESET;
        end else begin
            cfg_s1 <= structure;
            fmt_s1 <= format;
            if (tog_s2 != tog_s3) begin
                cfg_q <= cfg_s1;
                fmt_q <= fmt_s1;
            end
        end
    end

    // Six-cycle internal reset after every control write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_cnt <= 3'h0;
        end else if (tog_s2 != tog_s3) begin
            rst_cnt <= 3'(fir_ctrl_pkg::INT_RESET_CYCLES - 1); // [RULE11]
        end else if (rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            internal_reset_o <= 1'b0;
        end else begin
            internal_reset_o <= (tog_s2 != tog_s3) || (rst_cnt != 3'h0); // [RULE11]
        end
    end

    // ****************************************************************
    // Decoded configuration
    // ****************************************************************
    function automatic logic [11:0] round_weight(input logic [3:0] code);
        logic [11:0] w;
        w = 12'h000;
        if (code <= fir_ctrl_pkg::ROUND_MAX_CODE) begin
            w = 12'h001 << code; // [RULE21]
        end
        return w;
    endfunction

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            decim_delay_m1_o <= 4'h0;
            decim_factor_o <= 5'h01;
            dual_mode_o <= 1'b0;
            odd_sym_o <= 1'b0;
            even_taps_a_o <= 1'b0;
            even_taps_b_o <= 1'b0;
            b_from_own_port_o <= 1'b0;
            interleaved_o <= 1'b0;
            signed_fmt_o <= 4'h0;
            reversal_en_o <= 1'b1;
            round_en_o <= 1'b1;
            round_weight_o <= 12'h001;
        end else begin
            decim_delay_m1_o <= cfg_q[fir_ctrl_pkg::S_DECIM_LSB +: fir_ctrl_pkg::S_DECIM_W];
            decim_factor_o <= {1'b0, cfg_q[fir_ctrl_pkg::S_DECIM_LSB +: 4]} + 5'h01; // [RULE13]
            dual_mode_o <= cfg_q[fir_ctrl_pkg::S_DUAL]; // [RULE14]
            odd_sym_o <= cfg_q[fir_ctrl_pkg::S_ODD_SYM]; // [RULE15]
            even_taps_a_o <= cfg_q[fir_ctrl_pkg::S_EVEN_A]; // [RULE16]
            even_taps_b_o <= cfg_q[fir_ctrl_pkg::S_EVEN_B]; // [RULE16]
            b_from_own_port_o <= cfg_q[fir_ctrl_pkg::S_DUAL]
                & cfg_q[fir_ctrl_pkg::S_B_OWN_PORT]; // [RULE17]
            interleaved_o <= cfg_q[fir_ctrl_pkg::S_INTERLEAVE]; // [RULE18]
            signed_fmt_o <= fmt_q[fir_ctrl_pkg::F_SIGNED_A_DATA +: 4]; // [RULE19]
            reversal_en_o <= ~fmt_q[fir_ctrl_pkg::F_REVERSE_OFF]; // [RULE20]
            round_en_o <= ~fmt_q[fir_ctrl_pkg::F_ROUND_OFF]; // [RULE22]
            round_weight_o <= round_weight(fmt_q[fir_ctrl_pkg::F_ROUND_LSB +: 4]);
        end
    end

    // ****************************************************************
    // Control pin sampling
    // ****************************************************************
    logic swap_q;
    logic swap_prev;
    logic acc_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin // [RULE6]
        if (!arst_n_i) begin
            shift_en_o <= 1'b0;
            fwd_pass_o <= 1'b0;
            rev_pass_o <= 1'b0;
            subtract_o <= 1'b0;
            negate_a_o <= 1'b0;
            swap_q <= 1'b1;
            acc_q <= 1'b0;
            combiner_o <= 2'h0;
        end else begin
            shift_en_o <= ~shift_hold_n_i & ~internal_reset_o; // [RULE1]
            fwd_pass_o <= ~forward_operand_sel_n_i; // [RULE2]
            rev_pass_o <= ~reverse_operand_sel_n_i; // [RULE3]
            subtract_o <= ~forward_operand_sel_n_i & ~reverse_operand_sel_n_i & odd_sym_o;
            negate_a_o <= ~forward_operand_sel_n_i & reverse_operand_sel_n_i & odd_sym_o;
            swap_q <= lifo_swap_n_i;
            acc_q <= accumulate_gate_i;
            combiner_o <= combiner_ctrl_i;
        end
    end

    // Falling edge of sampled swap flips LIFO roles once
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            swap_prev <= 1'b1;
            lifo_sel_o <= 1'b0;
        end else begin
            swap_prev <= swap_q;
            if (internal_reset_o) begin
                lifo_sel_o <= 1'b0;
            end else if (swap_prev && !swap_q) begin
                lifo_sel_o <= ~lifo_sel_o; // [RULE4]
            end
        end
    end

    // Accumulate high feeds back; low zeroes feedback and loads output
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_feedback_en_o <= 1'b0;
            acc_load_o <= 1'b0;
        end else begin
            acc_feedback_en_o <= acc_q; // [RULE5]
            acc_load_o <= ~acc_q; // [RULE5]
        end
    end

    // ****************************************************************
    // Sample input registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sample_a_o <= 10'h000;
            sample_b_o <= 10'h000;
        end else if (!shift_hold_n_i) begin
            sample_a_o <= sample_port_a_i; // [RULE1]
            if (!b_from_own_port_o) begin
                sample_b_o <= sample_port_a_i; // [RULE17]
            end else if (low_bits_drive_n_i) begin
                sample_b_o <= {shared_b_upper_bits_i, sample_port_b_i[0]}; // [RULE7]
            end else begin
                sample_b_o <= {9'h000, sample_port_b_i[0]};
            end
        end
    end

    // ****************************************************************
    // Result pins
    // ****************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_low_bits_o <= 9'h000;
            result_high_bits_o <= 19'h00000;
        end else begin
            result_low_bits_o <= filter_result_i[8:0];
            result_high_bits_o <= filter_result_i[27:9];
        end
    end

    // Enables follow their pins through a register with no extra logic
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_low_bits_oe_n_o <= 1'b1;
            result_high_bits_oe_n_o <= 1'b1;
        end else begin
            result_low_bits_oe_n_o <= low_bits_drive_n_i; // [RULE7]
            result_high_bits_oe_n_o <= high_bits_drive_n_i; // [RULE8]
        end
    end
endmodule

// *** pkg/fir_ctrl_pkg.sv ***
// Constants and field layout for the dual FIR control and configuration block
// Overview of operation
// [RULE1] Shift hold low loads samples, advances delays
// [RULE2] Forward select low passes A operand, else zero
// [RULE3] Reverse select low passes B operand, else zero
// [RULE4] Falling swap edge exchanges filling and draining LIFOs
// [RULE5] Accumulate high accumulates; low zeroes feedback, loads output
// [RULE6] All control pins registered on rising clock edge
// [RULE7] Low enable low drives nine low bits
// [RULE8] High enable low drives nineteen upper bits, asynchronously; the code registers the enable on the rising clock edge
// [RULE9] Config word stored to register zero or one
// [RULE10] Host never writes reserved addresses two to FF
// [RULE11] Register write triggers six-cycle internal reset
// [RULE12] Config writes accepted asynchronously to clock
// [RULE13] Register zero bits 0-3 set decimation delay
// [RULE14] Register zero bit 4 selects single or dual
// [RULE15] Register zero bit 5 selects even/odd symmetry
// [RULE16] Register zero bits 6,7 set tap parity
// [RULE17] Register zero bit 8 picks filter B source
// [RULE18] Register zero bit 9 selects interleaved coefficient sets
// [RULE19] Register one bits 0-3 set data formats
// [RULE20] Register one bit 4 low enables reversal
// [RULE21] Register one bits 5-8 set rounding weight
// [RULE22] Register one bit 9 low enables rounding
// [RULE23] Coefficient writes use address bit 8 set
// [RULE24] Host programs registers first, ignores outputs during reset
package fir_ctrl_pkg;
    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 10;
    localparam logic [8:0] ADDR_STRUCT = 9'h000;
    localparam logic [8:0] ADDR_FORMAT = 9'h001;
    localparam int ADDR_COEF_BIT = 8;
    localparam logic [9:0] CFG_RESET = 10'h000;
    // ****************************************************************
    // Register 0 fields
    // ****************************************************************
    localparam int S_DECIM_LSB = 0;
    localparam int S_DECIM_W = 4;
    localparam int S_DUAL = 4;
    localparam int S_ODD_SYM = 5;
    localparam int S_EVEN_A = 6;
    localparam int S_EVEN_B = 7;
    localparam int S_B_OWN_PORT = 8;
    localparam int S_INTERLEAVE = 9;
    // ****************************************************************
    // Register 1 fields
    // ****************************************************************
    localparam int F_SIGNED_A_DATA = 0;
    localparam int F_SIGNED_A_COEF = 1;
    localparam int F_SIGNED_B_DATA = 2;
    localparam int F_SIGNED_B_COEF = 3;
    localparam int F_REVERSE_OFF = 4;
    localparam int F_ROUND_LSB = 5;
    localparam int F_ROUND_W = 4;
    localparam int F_ROUND_OFF = 9;
    localparam logic [3:0] ROUND_MAX_CODE = 4'hB;
    // ****************************************************************
    // Timing and result widths
    // ****************************************************************
    localparam int INT_RESET_CYCLES = 6;
    localparam int RESULT_W = 28;
    localparam int LOW_BITS_W = 9;
    localparam int HIGH_BITS_W = 19;
endpackage

// *** tb/fir_ctrl_host.sv ***
// Host-side model that drives the configuration write port
`timescale 1ns/1ns
module fir_ctrl_host (
    // Clock
    input wire logic clk_i,
    // Configuration port
    output logic wr_n_o,
    output logic [8:0] cfg_addr_o,
    output logic [9:0] cfg_word_o
);
    initial begin
        wr_n_o = 1'b1;
        cfg_addr_o = 9'h1FF;
        cfg_word_o = 10'h3FF;
    end
    // Strobe is placed at an arbitrary phase of the system clock
    // Reserved addresses are never written; both registers go first
    task automatic write(input logic [8:0] addr, input logic [9:0] data);
        #7;
        cfg_addr_o = addr;
        cfg_word_o = data;
        #11 wr_n_o = 1'b0;
        #29 wr_n_o = 1'b1;
        repeat (3) @(posedge clk_i);
        #3;
        cfg_addr_o = ~addr;
        cfg_word_o = ~data;
    endtask
endmodule

// *** tb/fir_ctrl_monitor.sv ***
// Assertion checker for the dual FIR control pins and configuration decode
`timescale 1ns/1ns
module fir_ctrl_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control inputs
    input wire logic shift_hold_n_i,
    input wire logic forward_operand_sel_n_i,
    input wire logic reverse_operand_sel_n_i,
    input wire logic lifo_swap_n_i,
    input wire logic accumulate_gate_i,
    input wire logic [1:0] combiner_ctrl_i,
    input wire logic low_bits_drive_n_i,
    input wire logic high_bits_drive_n_i,
    // Watched outputs
    input wire logic [9:0] sample_a_o,
    input wire logic shift_en_o,
    input wire logic fwd_pass_o,
    input wire logic rev_pass_o,
    input wire logic lifo_sel_o,
    input wire logic acc_feedback_en_o,
    input wire logic [1:0] combiner_o,
    input wire logic [3:0] decim_delay_m1_o,
    input wire logic [4:0] decim_factor_o,
    input wire logic internal_reset_o,
    input wire logic result_low_bits_oe_n_o,
    input wire logic result_high_bits_oe_n_o
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i || internal_reset_o);
    sequence s_swap_fall;
        $fell(lifo_swap_n_i);
    endsequence
    sequence s_swap_held;
        (!lifo_swap_n_i)[*5];
    endsequence
    sequence s_reset_span;
        internal_reset_o[*6] ##1 !internal_reset_o;
    endsequence
    property p_shift_hold;
        shift_hold_n_i |=> !shift_en_o && $stable(sample_a_o);
    endproperty
    property p_fwd;
        1'b1 |=> fwd_pass_o == !$past(forward_operand_sel_n_i);
    endproperty
    property p_rev;
        1'b1 |=> rev_pass_o == !$past(reverse_operand_sel_n_i);
    endproperty
    property p_swap;
        s_swap_fall |-> ##[1:3] $changed(lifo_sel_o);
    endproperty
    property p_swap_held;
        s_swap_held |-> $stable(lifo_sel_o);
    endproperty
    property p_acc;
        1'b1 |-> acc_feedback_en_o == $past(accumulate_gate_i, 2);
    endproperty
    property p_comb;
        1'b1 |-> combiner_o == $past(combiner_ctrl_i);
    endproperty
    property p_oe_low;
        1'b1 |-> result_low_bits_oe_n_o == $past(low_bits_drive_n_i);
    endproperty
    property p_oe_high;
        1'b1 |-> result_high_bits_oe_n_o == $past(high_bits_drive_n_i);
    endproperty
    property p_int_reset;
        disable iff (!arst_n_i) $rose(internal_reset_o) |-> s_reset_span;
    endproperty
    property p_decim;
        decim_factor_o == {1'b0, decim_delay_m1_o} + 5'h01;
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift hold ignored");
    a_fwd: assert property (p_fwd) else $error("forward gate wrong");
    a_rev: assert property (p_rev) else $error("reverse gate wrong");
    a_swap: assert property (p_swap) else $error("no lifo swap");
    a_swap_held: assert property (p_swap_held) else $error("extra lifo swap");
    a_acc: assert property (p_acc) else $error("accumulate gate wrong");
    a_comb: assert property (p_comb) else $error("combiner not registered");
    a_oe_low: assert property (p_oe_low) else $error("low enable wrong");
    a_oe_high: assert property (p_oe_high) else $error("high enable wrong");
    a_int_reset: assert property (p_int_reset) else $error("reset span not six");
    a_decim: assert property (p_decim) else $error("factor not code plus one");
endmodule
bind fir_ctrl_top fir_ctrl_monitor fir_ctrl_monitor_inst (.clk_i, .arst_n_i, .shift_hold_n_i,
    .forward_operand_sel_n_i, .reverse_operand_sel_n_i, .lifo_swap_n_i, .accumulate_gate_i,
    .combiner_ctrl_i, .low_bits_drive_n_i, .high_bits_drive_n_i, .sample_a_o, .shift_en_o,
    .fwd_pass_o, .rev_pass_o, .lifo_sel_o, .acc_feedback_en_o, .combiner_o, .decim_delay_m1_o,
    .decim_factor_o, .internal_reset_o, .result_low_bits_oe_n_o, .result_high_bits_oe_n_o);

// *** tb/fir_ctrl_top_tb.sv ***
// Self-checking testbench for the dual FIR control and configuration block
`timescale 1ns/1ns
module fir_ctrl_top_tb;
    logic clk_i, arst_n_i, shift_hold_n_i, forward_operand_sel_n_i, reverse_operand_sel_n_i;
    logic lifo_swap_n_i, accumulate_gate_i, low_bits_drive_n_i, high_bits_drive_n_i, wr_n_i;
    logic [1:0] combiner_ctrl_i, combiner_o;
    logic [8:0] cfg_addr_i, shared_b_upper_bits_i, result_low_bits_o;
    logic [9:0] cfg_word_in_i, sample_port_a_i, sample_port_b_i, sample_a_o, sample_b_o, w;
    logic [27:0] filter_result_i;
    logic shift_en_o, fwd_pass_o, rev_pass_o, lifo_sel_o, acc_feedback_en_o, dual_mode_o, v;
    logic odd_sym_o, even_taps_a_o, even_taps_b_o, b_from_own_port_o, interleaved_o;
    logic reversal_en_o, round_en_o, internal_reset_o, result_low_bits_oe_n_o;
    logic result_high_bits_oe_n_o, subtract_o, negate_a_o, acc_load_o;
    logic [3:0] decim_delay_m1_o, signed_fmt_o;
    logic [4:0] decim_factor_o;
    logic [11:0] round_weight_o;
    logic [18:0] result_high_bits_o;
    int errors = 0;
    int checks = 0;
    int i;
    fir_ctrl_top fir_ctrl_top_inst (.clk_i, .arst_n_i, .shift_hold_n_i, .forward_operand_sel_n_i,
        .reverse_operand_sel_n_i, .lifo_swap_n_i, .accumulate_gate_i, .combiner_ctrl_i,
        .low_bits_drive_n_i, .high_bits_drive_n_i, .wr_n_i, .cfg_addr_i, .cfg_word_in_i,
        .sample_port_a_i, .sample_port_b_i, .shared_b_upper_bits_i, .filter_result_i,
        .sample_a_o, .sample_b_o, .shift_en_o, .fwd_pass_o, .rev_pass_o, .subtract_o,
        .negate_a_o, .lifo_sel_o, .acc_feedback_en_o, .acc_load_o, .combiner_o,
        .decim_delay_m1_o, .decim_factor_o, .dual_mode_o, .odd_sym_o, .even_taps_a_o,
        .even_taps_b_o, .b_from_own_port_o, .interleaved_o, .signed_fmt_o, .reversal_en_o,
        .round_en_o, .round_weight_o, .internal_reset_o, .result_low_bits_o,
        .result_low_bits_oe_n_o, .result_high_bits_o, .result_high_bits_oe_n_o);
    fir_ctrl_host fir_ctrl_host_inst (.clk_i, .wr_n_o(wr_n_i), .cfg_addr_o(cfg_addr_i),
        .cfg_word_o(cfg_word_in_i));
    // ****************************************************************
    // Clock, watchdog and helpers
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    task automatic complete_run();
        $display("Counts: %0d mismatches in %0d comparisons", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Write through the host, then count internal reset cycles
    task automatic cfg_write(input logic [8:0] a, input logic [9:0] d, input int len);
        int n;
        n = 0;
        fork
            fir_ctrl_host_inst.write(a, d);
        join_none
        repeat (24) begin
            @(negedge clk_i);
            if (internal_reset_o === 1'b1) n++;
        end
        check(n, len, "reset length");
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {shift_hold_n_i, forward_operand_sel_n_i, reverse_operand_sel_n_i} = 3'h7;
        {lifo_swap_n_i, low_bits_drive_n_i, high_bits_drive_n_i} = 3'h7;
        accumulate_gate_i = 1'b0;
        combiner_ctrl_i = 2'h0;
        {sample_port_a_i, sample_port_b_i, shared_b_upper_bits_i} = 29'h0;
        filter_result_i = 28'h0;
        arst_n_i = 1'b0;
        cyc(4);
        arst_n_i = 1'b1;
        cyc(1);
        check(decim_factor_o, 5'h01, "reset factor");
        check({reversal_en_o, round_en_o, round_weight_o}, 14'h3001, "reset format");
        check({result_high_bits_oe_n_o, result_low_bits_oe_n_o}, 2'h3, "reset oe");
        for (i = 0; i < 16; i++) begin
            w = {i[2], i[3:0], ~i[1], i[3:0]};
            cfg_write(9'h001, w, 6);
            check(signed_fmt_o, w[3:0], "formats");
            check(reversal_en_o, !w[4], "reversal");
            check(round_weight_o, i < 12 ? 12'h001 << i : 12'h000, "round weight");
            check(round_en_o, !w[9], "round enable");
        end
        for (i = 0; i < 16; i++) begin
            w = {i[0] ^ i[1], 1'b1, ~i[3:0], i[3:0]};
            cfg_write(9'h000, w, 6);
            check(decim_delay_m1_o, i[3:0], "decim code");
            check(decim_factor_o, i + 1, "decim factor");
            check(dual_mode_o, w[4], "dual");
            check(odd_sym_o, w[5], "symmetry");
            check({even_taps_b_o, even_taps_a_o}, w[7:6], "tap parity");
            check(b_from_own_port_o, w[8] & w[4], "b source");
            check(interleaved_o, w[9], "interleave");
        end
        shift_hold_n_i = 1'b0;
        sample_port_a_i = 10'h2A5;
        sample_port_b_i = 10'h15B;
        shared_b_upper_bits_i = 9'h0C3;
        cyc(2);
        check(sample_b_o, 10'h2A5, "b from port a");
        cfg_write(9'h000, 10'h130, 6);
        cfg_write(9'h1FF, 10'h3FF, 0);
        cfg_write(9'h100, 10'h3FF, 0);
        check({dual_mode_o, decim_delay_m1_o}, 5'h10, "ignored write");
        cyc(1);
        check(sample_b_o, {9'h0C3, 1'b1}, "b own port");
        check({shift_en_o, sample_a_o}, 11'h6A5, "sample load");
        shift_hold_n_i = 1'b1;
        sample_port_a_i = 10'h0F0;
        cyc(2);
        check({shift_en_o, sample_a_o}, 11'h2A5, "sample hold");
        for (i = 0; i < 4; i++) begin
            {reverse_operand_sel_n_i, forward_operand_sel_n_i} = i[1:0];
            accumulate_gate_i = i[0];
            combiner_ctrl_i = i[1:0];
            cyc(3);
            check(fwd_pass_o, !i[0], "forward gate");
            check(rev_pass_o, !i[1], "reverse gate");
            check(acc_feedback_en_o, i[0], "accumulate");
            check(acc_load_o, !i[0], "accumulator load");
            check({subtract_o, negate_a_o}, {!i[0] & !i[1], !i[0] & i[1]}, "alu op");
            check(combiner_o, i[1:0], "combiner");
        end
        accumulate_gate_i = 1'b0;
        v = lifo_sel_o;
        lifo_swap_n_i = 1'b0;
        cyc(4);
        check(lifo_sel_o, !v, "swap");
        cyc(4);
        check(lifo_sel_o, !v, "held low");
        lifo_swap_n_i = 1'b1;
        cyc(1);
        lifo_swap_n_i = 1'b0;
        cyc(4);
        check(lifo_sel_o, v, "swap back");
        lifo_swap_n_i = 1'b1;
        filter_result_i = 28'hA5C3E69;
        {low_bits_drive_n_i, high_bits_drive_n_i, shift_hold_n_i} = 3'h0;
        cyc(2);
        check({result_high_bits_oe_n_o, result_low_bits_oe_n_o}, 2'h0, "oe on");
        check({result_high_bits_o, result_low_bits_o}, 28'hA5C3E69, "result");
        check(sample_b_o, {9'h000, 1'b1}, "b upper masked");
        high_bits_drive_n_i = 1'b1;
        cyc(2);
        check({result_high_bits_oe_n_o, result_low_bits_oe_n_o}, 2'h2, "oe high off");
        complete_run();
    end
endmodule
